// [bench/line_loopback_control_chk.sv]
`timescale 1ns/100ps
`include "loopback_defs.vh"
module line_loopback_control_chk
(
   input wire core_clk,
   input wire resetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire mux_pin_in,
   input wire transmit_clock,
   input wire recovered_clock_in,
   input wire liu_connected,
   input wire transmit_power_down,
   input wire tx_channel_clock,
   input wire tx_channel_block,
   input wire rx_via_jitter_atten,
   input wire framer_rx_clock,
   input wire tx_link_clock,
   input wire tx_regen_overhead
);
// ------------------------------------------------------------
// Shadow of the control register and a settling window
// ------------------------------------------------------------
reg [7:0] ctrl_q;
reg [11:0] wa_q;
reg [7:0] wd_q;
reg ws_q;
reg pin_q;
reg [3:0] quiet_q;
wire quiet = (quiet_q == 4'hF);
wire ctrl_wr = s_axi_bvalid && s_axi_bready && ws_q
   && s_axi_bresp == `RESP_OKAY && wa_q == {`CTRL_IDX, 2'b00};
// Outputs judged only once synchronisers settle
always @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      ctrl_q <= 8'h00;
      wa_q <= 12'h000;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      pin_q <= 1'b0;
      quiet_q <= 4'h0;
   end
   else
   begin
      if (s_axi_awvalid && s_axi_awready)
         wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         {ws_q, wd_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (ctrl_wr)
         ctrl_q <= wd_q;
      pin_q <= mux_pin_in;
      if (s_axi_bvalid || pin_q != mux_pin_in)
         quiet_q <= 4'h0;
      else if (!quiet)
         quiet_q <= quiet_q + 4'h1;
   end
end
default clocking cb @(posedge core_clk); endclocking
default disable iff (!resetn);
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
chk_mux_state: assert property (quiet |-> liu_connected ==
   ((ctrl_q[7] | pin_q) & ~ctrl_q[4])) else $error("mux state wrong");
chk_power_down: assert property (quiet |-> transmit_power_down ==
   (ctrl_q[7] & pin_q)) else $error("power down wrong");
chk_strobe_blank: assert property (quiet && ctrl_q[1] |->
   !tx_channel_clock && !tx_channel_block) else $error("strobes live");
chk_local_route: assert property (quiet |-> rx_via_jitter_atten ==
   (ctrl_q[3] & ~ctrl_q[0])) else $error("local route wrong");
chk_framer_clock: assert property (quiet && ctrl_q[0] &&
   $rose(framer_rx_clock) |-> transmit_clock) else $error("rx clock src");
chk_link_clock: assert property (quiet && ctrl_q[1] &&
   $rose(tx_link_clock) |-> recovered_clock_in) else $error("link clock");
chk_regen_gate: assert property (quiet && tx_regen_overhead |->
   ctrl_q[1]) else $error("overhead regen outside payload loop");
chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
   s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late");
chk_busy_ready: assert property (s_axi_bvalid |->
   !s_axi_awready && !s_axi_wready) else $error("ready while busy");
chk_bus_release: assert property (s_axi_bvalid && s_axi_bready |=>
   !s_axi_bvalid ##0 s_axi_awready) else $error("write not released");
cover property (quiet && ctrl_q[1] && tx_regen_overhead);
cover property (quiet && ctrl_q[0] && $rose(framer_rx_clock));
cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule
bind line_loopback_control line_loopback_control_chk chk_u (.*);

// [bench/line_partner.sv]
`timescale 1ns/100ps
module line_partner
(
   input wire shared_timing,
   input wire [1:0] line_bits,
   output reg transmit_clock,
   output reg recovered_clock_in,
   output reg line_rx_positive_in,
   output reg line_rx_negative_in
);
// Line clock runs free; offset keeps its edges off the core edges
initial
begin
   transmit_clock = 1'b0;
   line_rx_positive_in = 1'b0;
   line_rx_negative_in = 1'b0;
   #2;
   forever #40 transmit_clock = ~transmit_clock;
end
// Recovered clock half a bit away unless both sides share one timing
always @*
   recovered_clock_in = shared_timing ? transmit_clock : ~transmit_clock;
// Symbols launched on the falling edge and held a whole bit
always @(negedge recovered_clock_in)
   {line_rx_positive_in, line_rx_negative_in} <= line_bits;
endmodule

// [bench/tb_line_loopback_control.sv]
`timescale 1ns/100ps
`include "loopback_defs.vh"
module tb_line_loopback_control;
// ------------------------------------------------------------
// Signals
// ------------------------------------------------------------
logic core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, shared_timing;
logic [11:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, bq;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, line_bits, br;
logic t1_mode, recovered_clock_in, transmit_clock, line_rx_positive_in;
logic line_rx_negative_in, fmt_tx_positive_in, fmt_tx_negative_in;
logic framer_tx_positive_in, framer_tx_negative_in, mux_pin_in;
logic receive_frame_sync, tx_serial_in, rx_payload_in;
logic tx_channel_clock_in, tx_channel_block_in, line_tx_positive_out;
logic line_tx_negative_out, liu_tx_positive_out, liu_tx_negative_out;
logic tx_link_clock, tx_channel_clock, tx_channel_block;
logic tx_formatter_data, tx_regen_overhead, framer_rx_positive;
logic framer_rx_negative, framer_rx_clock, rx_via_jitter_atten;
logic liu_connected, transmit_power_down;
integer failures, samples_checked;
localparam [11:0] a_ctrl = {`CTRL_IDX, 2'b00};
localparam [11:0] a_ch1 = {`CHEN1_IDX, 2'b00};
line_loopback_control dut_u (.*);
line_partner far_u (.*);
// Core clock
always #2.5 core_clk = ~core_clk;
// ------------------------------------------------------------
// Shared tasks
// ------------------------------------------------------------
task chk(input [31:0] got, input [31:0] exp);
begin
   samples_checked = samples_checked + 1;
   if (got !== exp)
   begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
   end
end
endtask
// One bus transfer, write or read
task bus(input wr, input [11:0] a, input [7:0] d, output [31:0] q,
   output [1:0] r);
   integer n;
   logic done, ta, tw, tr;
begin
   n = 0;
   done = 1'b0;
   @(posedge core_clk);
   s_axi_awaddr <= a;
   s_axi_araddr <= a;
   s_axi_wdata <= {24'h000000, d};
   {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
   {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
   while (!done && n < 200)
   begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      done = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
      n = n + 1;
   end
   if (!done) failures = failures + 1;
end
endtask
task wr8(input [11:0] a, input [7:0] d);
begin
   bus(1'b1, a, d, bq, br);
   chk(br, `RESP_OKAY);
end
endtask
task rd_chk(input [11:0] a, input [31:0] e);
begin
   bus(1'b0, a, 8'h00, bq, br);
   chk(bq, e);
   chk(br, `RESP_OKAY);
end
endtask
// Writes the control byte, then lets the link synchronisers settle
task set_ctrl(input [7:0] v);
begin
   wr8(a_ctrl, v);
   repeat (120) @(posedge core_clk);
end
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task t_regs;
   integer i;
begin
   for (i = 0; i < 5; i = i + 1)
      rd_chk(a_ctrl + {i[9:0], 2'b00}, 32'h0);
   for (i = 0; i < 4; i = i + 1)
      wr8(a_ch1 + {i[9:0], 2'b00}, 8'h3C ^ i[7:0]);
   for (i = 0; i < 4; i = i + 1)
      rd_chk(a_ch1 + {i[9:0], 2'b00}, {24'h0, 8'h3C ^ i[7:0]});
   bus(1'b1, 12'h100, 8'hFF, bq, br);
   chk(br, `RESP_SLVERR);
   bus(1'b0, 12'h100, 8'h00, bq, br);
   chk({bq[29:0], br}, {30'h0, `RESP_SLVERR});
   rd_chk(a_ctrl, 32'h0);
   $display("register test done");
end
endtask
task mux_case(input [7:0] c, input p, input econ, input epd);
begin
   mux_pin_in <= p;
   set_ctrl(c);
   chk(liu_connected, econ);
   chk(transmit_power_down, epd);
   chk(liu_tx_positive_out, econ);
end
endtask
task t_mux;
begin
   mux_case(8'h00, 1'b0, 1'b0, 1'b0);
   mux_case(8'h10, 1'b0, 1'b0, 1'b0);
   mux_case(8'h00, 1'b1, 1'b1, 1'b0);
   mux_case(8'h10, 1'b1, 1'b0, 1'b0);
   mux_case(8'h80, 1'b0, 1'b1, 1'b0);
   mux_case(8'h90, 1'b1, 1'b0, 1'b1);
   mux_case(8'h80, 1'b1, 1'b1, 1'b1);
   mux_pin_in <= 1'b0;
   $display("mux test done");
end
endtask
task route_case(input [7:0] c, input t1, input fp, input [1:0] lb,
   input [3:0] e);
begin
   t1_mode <= t1;
   fmt_tx_positive_in <= fp;
   line_bits <= lb;
   set_ctrl(c);
   chk({line_tx_positive_out, line_tx_negative_out} & ~{t1, t1}, e[3:2]);
   chk({framer_rx_positive, rx_via_jitter_atten}, e[1:0]);
end
endtask
task t_route;
begin
   route_case(8'h00, 1'b0, 1'b1, 2'b01, 4'b1000);
   route_case(8'h04, 1'b0, 1'b1, 2'b01, 4'b0100);
   route_case(8'h01, 1'b0, 1'b0, 2'b10, 4'b0000);
   route_case(8'h08, 1'b0, 1'b1, 2'b01, 4'b1011);
   route_case(8'h09, 1'b0, 1'b1, 2'b01, 4'b1010);
   route_case(8'h01, 1'b1, 1'b0, 2'b10, 4'b0000);
   chk(line_tx_positive_out ^ line_tx_negative_out, 1);
   $display("route test done");
end
endtask
task t_strobe;
begin
   {tx_channel_clock_in, tx_channel_block_in} <= 2'b11;
   set_ctrl(8'h00);
   chk({tx_channel_clock, tx_channel_block}, 2'b11);
   set_ctrl(8'h02);
   chk({tx_channel_clock, tx_channel_block}, 2'b00);
   $display("strobe test done");
end
endtask
// Counts formatter ones and overhead slots over one whole frame
task count_case(input [7:0] c, input [31:0] ch, input t1, input ser,
   input pay, input integer n, input integer eones, input integer ereg);
   integer i, ones, regen;
begin
   t1_mode <= t1;
   {tx_serial_in, rx_payload_in} <= {ser, pay};
   for (i = 0; i < 4; i = i + 1)
      wr8(a_ch1 + {i[9:0], 2'b00}, ch[8 * i +: 8]);
   set_ctrl(c);
   ones = 0;
   regen = 0;
   repeat (n)
   begin
      if (c[1]) @(negedge recovered_clock_in);
      else @(negedge transmit_clock);
      ones = ones + tx_formatter_data;
      regen = regen + tx_regen_overhead;
   end
   chk(ones, eones);
   chk(regen, ereg);
end
endtask
task t_count;
begin
   count_case(8'h00, 32'hFFFFFFFF, 0, 0, 1, 256, 248, 0);
   count_case(8'h00, 32'h00800001, 1, 0, 1, 193, 16, 0);
   count_case(8'h00, 32'h00000000, 0, 1, 0, 256, 248, 0);
   count_case(8'h02, 32'h00000000, 1, 0, 1, 193, 192, 1);
   count_case(8'h02, 32'h00000000, 0, 1, 0, 256, 0, 8);
   $display("frame count test done");
end
endtask
task end_of_test;
begin
   $display("checks %0d mismatches %0d", samples_checked, failures);
   if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
   else
      $display("*** FAIL ***");
   $finish;
end
endtask
// Watchdog: the whole sequence needs about 105 us
initial
begin
   #300000;
   failures = failures + 1;
   end_of_test;
end
// Main sequence
initial
begin
   {core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
      s_axi_arvalid, s_axi_rready, t1_mode, fmt_tx_negative_in,
      framer_tx_positive_in, framer_tx_negative_in, mux_pin_in,
      receive_frame_sync, tx_serial_in, rx_payload_in, tx_channel_clock_in,
      tx_channel_block_in, shared_timing} = 18'h0;
   {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
   s_axi_wstrb = 4'hF;
   fmt_tx_positive_in = 1'b1;
   line_bits = 2'b01;
   failures = 0;
   samples_checked = 0;
   repeat (5) @(posedge core_clk);
   resetn <= 1'b1;
   t_regs;
   t_mux;
   t_route;
   t_strobe;
   shared_timing <= 1'b1;
   t_count;
   end_of_test;
end
endmodule

// [hdl/line_loopback_control.v]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "loopback_defs.vh"
module line_loopback_control
(
   input wire core_clk,
   input wire resetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire t1_mode,
   input wire recovered_clock_in,
   input wire transmit_clock,
   input wire line_rx_positive_in,
   input wire line_rx_negative_in,
   input wire fmt_tx_positive_in,
   input wire fmt_tx_negative_in,
   input wire framer_tx_positive_in,
   input wire framer_tx_negative_in,
   input wire mux_pin_in,
   input wire receive_frame_sync,
   input wire tx_serial_in,
   input wire rx_payload_in,
   input wire tx_channel_clock_in,
   input wire tx_channel_block_in,
   output reg line_tx_positive_out,
   output reg line_tx_negative_out,
   output reg liu_tx_positive_out,
   output reg liu_tx_negative_out,
   output reg tx_link_clock,
   output reg tx_channel_clock,
   output reg tx_channel_block,
   output reg tx_formatter_data,
   output reg tx_regen_overhead,
   output reg framer_rx_positive,
   output reg framer_rx_negative,
   output reg framer_rx_clock,
   output reg rx_via_jitter_atten,
   output reg liu_connected,
   output reg transmit_power_down
);

   // --------------------------------------------------------------
   // Register decode
   // --------------------------------------------------------------
   // Returns 0 for control, 1..4 for channel enables, 7 if unmapped
   function [2:0] reg_sel;
      input [11:0] addr;
      begin
         reg_sel = 3'h7;
         if (addr[1:0] == 2'h0)
         begin
            case (addr[11:2])
               `CTRL_IDX: reg_sel = 3'h0;
               `CHEN1_IDX: reg_sel = 3'h1;
               `CHEN2_IDX: reg_sel = 3'h2;
               `CHEN3_IDX: reg_sel = 3'h3;
               `CHEN4_IDX: reg_sel = 3'h4;
               default: reg_sel = 3'h7;
            endcase
         end
      end
   endfunction

   // Channel (enable bit index) of a bit position in the frame
   function [4:0] chan_of;
      input [8:0] pos;
      input t1;
      reg [8:0] p;
      begin
         p = t1 ? pos - 9'h001 : pos;
         chan_of = p[7:3];
      end
   endfunction

   reg [7:0] ctrl_q;
   reg [31:0] chen_q;
   reg [11:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg w_strb0_q;
   wire framer_lb = ctrl_q[`FRAMER_LB_BIT];
   wire payload_lb = ctrl_q[`PAYLOAD_LB_BIT];
   wire remote_lb = ctrl_q[`REMOTE_LB_BIT];
   wire local_lb = ctrl_q[`LOCAL_LB_BIT];
   wire [2:0] wsel = reg_sel(aw_addr_q);
   wire [2:0] rsel = reg_sel(s_axi_araddr);
   wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   // --------------------------------------------------------------
   // AXI4-Lite write channel
   // --------------------------------------------------------------
   // Address and data are taken in either order; once both are held,
   // the write lands in the same cycle as the response is raised.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h00000000;
         w_strb0_q <= 1'b0;
         ctrl_q <= `CTRL_RESET;
         chen_q <= `CHEN_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
            // Value stored as written, effective at once
            if (w_strb0_q && wsel == 3'h0)
               ctrl_q <= w_data_q[7:0];
            // Byte n of the enables holds channels 8n+1..8n+8
            if (w_strb0_q && wsel != 3'h0 && wsel != 3'h7)
               chen_q[(wsel - 3'h1) * 8 +: 8] <= w_data_q[7:0];
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // AXI4-Lite read channel
   // --------------------------------------------------------------
   // Reads return the stored byte; bits above read as zero
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (rsel)
               3'h0: s_axi_rdata <= {24'h000000, ctrl_q};
               3'h1: s_axi_rdata <= {24'h000000, chen_q[7:0]};
               3'h2: s_axi_rdata <= {24'h000000, chen_q[15:8]};
               3'h3: s_axi_rdata <= {24'h000000, chen_q[23:16]};
               3'h4: s_axi_rdata <= {24'h000000, chen_q[31:24]};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   // Every link pin is foreign to core_clk: three stages, and the
   // filtered level moves only when stages two and three agree.
   localparam NP = 14;
   localparam P_RCLK = 0;
   localparam P_TRANSMIT_CLOCK = 1;
   localparam P_RPOS = 2;
   localparam P_RNEG = 3;
   localparam P_FPOS = 4;
   localparam P_FNEG = 5;
   localparam P_XPOS = 6;
   localparam P_XNEG = 7;
   localparam P_MUX = 8;
   localparam P_RFS = 9;
   localparam P_TX_SERIAL_IN = 10;
   localparam P_RPAY = 11;
   localparam P_CHCLK = 12;
   localparam P_CHBLK = 13;
   wire [NP-1:0] pins = {tx_channel_block_in, tx_channel_clock_in,
      rx_payload_in, tx_serial_in, receive_frame_sync, mux_pin_in,
      framer_tx_negative_in, framer_tx_positive_in,
      fmt_tx_negative_in, fmt_tx_positive_in,
      line_rx_negative_in, line_rx_positive_in,
      transmit_clock, recovered_clock_in};
   reg [NP-1:0] s1_q;
   reg [NP-1:0] s2_q;
   reg [NP-1:0] s3_q;
   reg [NP-1:0] f_q;
   reg [NP-1:0] fp_q;
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi = gi + 1)
      begin : sync
         always @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               f_q[gi] <= 1'b0;
               fp_q[gi] <= 1'b0;
            end
            else
            begin
               s1_q[gi] <= pins[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  f_q[gi] <= s3_q[gi];
               fp_q[gi] <= f_q[gi];
            end
         end
      end
   endgenerate

   wire rclk_rise = f_q[P_RCLK] & ~fp_q[P_RCLK];
   wire transmit_clock_rise = f_q[P_TRANSMIT_CLOCK] & ~fp_q[P_TRANSMIT_CLOCK];
   wire rclk_fall = ~f_q[P_RCLK] & fp_q[P_RCLK];
   wire transmit_clock_fall = ~f_q[P_TRANSMIT_CLOCK] & fp_q[P_TRANSMIT_CLOCK];
   // Payload loop times the transmit path from the receive clock
   wire tx_rise = payload_lb ? rclk_rise : transmit_clock_rise;
   wire tx_fall = payload_lb ? rclk_fall : transmit_clock_fall;
   // Framer loop times the receive path from the transmit clock
   wire rx_rise = framer_lb ? transmit_clock_rise : rclk_rise;
   wire rfs_rise = f_q[P_RFS] & ~fp_q[P_RFS];

   // --------------------------------------------------------------
   // Two-entry transmit buffer
   // --------------------------------------------------------------
   // Filled on the transmit capture edge, drained onto the line on
   // the following falling edge; capture stalls while it is full.
   localparam BUF_W = 2;
   localparam BUF_D = 2;
   reg [BUF_W-1:0] buf_mem [0:BUF_D-1];
   reg buf_wp_q;
   reg buf_rp_q;
   reg [1:0] buf_cnt_q;
   wire buf_in_ready = (buf_cnt_q != 2'h2);
   wire buf_out_valid = (buf_cnt_q != 2'h0);
   wire buf_push = tx_rise & buf_in_ready;
   wire buf_pop = tx_fall & buf_out_valid;
   reg [BUF_W-1:0] tx_word_d;
   reg ami_q;

   // Word offered to the line: remote loop wins, then T1 framer
   // loop idle code, otherwise the formatter output.
   always @*
   begin
      tx_word_d = {f_q[P_FPOS], f_q[P_FNEG]};
      if (remote_lb)
         tx_word_d = {f_q[P_RPOS], f_q[P_RNEG]};
      else if (framer_lb && t1_mode)
         tx_word_d = {ami_q, ~ami_q};
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         buf_wp_q <= 1'b0;
         buf_rp_q <= 1'b0;
         buf_cnt_q <= 2'h0;
         buf_mem[0] <= 2'h0;
         buf_mem[1] <= 2'h0;
         ami_q <= 1'b0;
      end
      else
      begin
         if (buf_push)
         begin
            buf_mem[buf_wp_q] <= tx_word_d;
            buf_wp_q <= ~buf_wp_q;
            // Unframed marks alternate polarity
            ami_q <= ~ami_q;
         end
         if (buf_pop)
            buf_rp_q <= ~buf_rp_q;
         if (buf_push && !buf_pop)
            buf_cnt_q <= buf_cnt_q + 2'h1;
         else if (buf_pop && !buf_push)
            buf_cnt_q <= buf_cnt_q - 2'h1;
      end
   end

   // --------------------------------------------------------------
   // Frame position and payload source
   // --------------------------------------------------------------
   // The frame counter aligns to the receive frame sync; this only
   // matches the transmit frame when the system keeps both sides
   // synchronous.
   reg [8:0] pos_q;
   reg sync_pend_q;
   wire [8:0] frame_bits = t1_mode ? `T1_FRAME_BITS : `E1_FRAME_BITS;
   wire [8:0] pay_bits = t1_mode ? `T1_PAYLOAD_BITS : `E1_PAYLOAD_BITS;
   // Leading bits of each frame are overhead the transmitter rebuilds
   wire overhead = (pos_q < (frame_bits - pay_bits));
   wire [4:0] chan = chan_of(pos_q, t1_mode);
   wire chan_loop = chen_q[chan];

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pos_q <= 9'h000;
         sync_pend_q <= 1'b0;
         tx_formatter_data <= 1'b0;
         tx_regen_overhead <= 1'b0;
      end
      else
      begin
         // A sync seen while its pending flag clears is kept
         if (rfs_rise)
            sync_pend_q <= 1'b1;
         else if (tx_rise)
            sync_pend_q <= 1'b0;
         if (tx_rise)
         begin
            // A count left over from the longer E1 frame wraps at once
            if (sync_pend_q || pos_q >= frame_bits - 9'h001)
               pos_q <= 9'h000;
            else
               pos_q <= pos_q + 9'h001;
            tx_regen_overhead <= payload_lb & overhead;
            if (overhead)
               tx_formatter_data <= 1'b0;
            // Payload loop ignores the backplane serial input
            else if (payload_lb || chan_loop)
               tx_formatter_data <= f_q[P_RPAY];
            else
               tx_formatter_data <= f_q[P_TX_SERIAL_IN];
         end
      end
   end

   // --------------------------------------------------------------
   // Interface mux and pin role
   // --------------------------------------------------------------
   wire pin_is_mux = ~ctrl_q[`PIN_FUNC_BIT];
   wire bit_rules = ctrl_q[`PIN_FUNC_BIT] | f_q[P_MUX];
   // With the mux role and the pin low, the bit has no say
   wire liu_conn_d = bit_rules & ~ctrl_q[`MUX_CTRL_BIT];

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         liu_connected <= 1'b0;
         transmit_power_down <= 1'b0;
      end
      else
      begin
         liu_connected <= liu_conn_d;
         transmit_power_down <= ~pin_is_mux & f_q[P_MUX];
      end
   end

   // --------------------------------------------------------------
   // Transmit line outputs and clocks
   // --------------------------------------------------------------
   // When separated the line unit takes the external framer pins
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         line_tx_positive_out <= 1'b0;
         line_tx_negative_out <= 1'b0;
         liu_tx_positive_out <= 1'b0;
         liu_tx_negative_out <= 1'b0;
         tx_link_clock <= 1'b0;
         tx_channel_clock <= 1'b0;
         tx_channel_block <= 1'b0;
      end
      else
      begin
         if (buf_pop)
         begin
            line_tx_positive_out <= buf_mem[buf_rp_q][1];
            line_tx_negative_out <= buf_mem[buf_rp_q][0];
         end
         liu_tx_positive_out <= liu_conn_d ?
            line_tx_positive_out : f_q[P_XPOS];
         liu_tx_negative_out <= liu_conn_d ?
            line_tx_negative_out : f_q[P_XNEG];
         tx_link_clock <= payload_lb ? f_q[P_RCLK] : f_q[P_TRANSMIT_CLOCK];
         // Channel strobes held low while the payload is looped
         tx_channel_clock <= ~payload_lb & f_q[P_CHCLK];
         tx_channel_block <= ~payload_lb & f_q[P_CHBLK];
      end
   end

   // --------------------------------------------------------------
   // Receive path into the framer
   // --------------------------------------------------------------
   // Framer loop replaces line data with formatter data; local loop
   // replaces it with what was sent, routed through the attenuator.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         framer_rx_positive <= 1'b0;
         framer_rx_negative <= 1'b0;
         framer_rx_clock <= 1'b0;
         rx_via_jitter_atten <= 1'b0;
      end
      else
      begin
         framer_rx_clock <= framer_lb ? f_q[P_TRANSMIT_CLOCK] : f_q[P_RCLK];
         rx_via_jitter_atten <= local_lb & ~framer_lb;
         if (rx_rise)
         begin
            if (framer_lb)
            begin
               framer_rx_positive <= f_q[P_FPOS];
               framer_rx_negative <= f_q[P_FNEG];
            end
            else if (local_lb)
            begin
               framer_rx_positive <= line_tx_positive_out;
               framer_rx_negative <= line_tx_negative_out;
            end
            else
            begin
               framer_rx_positive <= f_q[P_RPOS];
               framer_rx_negative <= f_q[P_RNEG];
            end
         end
      end
   end

endmodule

// [hdl/loopback_defs.vh]
`ifndef LOOPBACK_DEFS_VH
`define LOOPBACK_DEFS_VH
// --------------------------------------------------------------
// Register indices; the byte address is four times the index
// --------------------------------------------------------------
`define CTRL_IDX 10'h04A
`define CHEN1_IDX 10'h04B
`define CHEN2_IDX 10'h04C
`define CHEN3_IDX 10'h04D
`define CHEN4_IDX 10'h04E
`define AXI_ADDR_W 12
// --------------------------------------------------------------
// Loopback control field positions and reset values
// --------------------------------------------------------------
`define FRAMER_LB_BIT 0
`define PAYLOAD_LB_BIT 1
`define REMOTE_LB_BIT 2
`define LOCAL_LB_BIT 3
`define MUX_CTRL_BIT 4
`define PIN_FUNC_BIT 7
`define CTRL_RESET 8'h00
`define CHEN_RESET 32'h00000000
// --------------------------------------------------------------
// Frame geometry in bits
// --------------------------------------------------------------
`define T1_FRAME_BITS 9'h0C1
`define T1_PAYLOAD_BITS 9'h0C0
`define E1_FRAME_BITS 9'h100
`define E1_PAYLOAD_BITS 9'h0F8
// --------------------------------------------------------------
// Bus answers
// --------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif
